// ==== core/btsc_pkg.sv ====
// Package for the bit-test, skip and call unit.
// Assumes an 11-bit program counter and an 8-bit data path.
package btsc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W    = 11;
  localparam int DATA_W  = 8;
  localparam int BIT_W   = 3;
  localparam int HI_W    = 3;
  localparam int SP_W    = 3;

  // ----------------------------------------------------------------
  // Operation codes presented to the unit
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_NONE  = 3'h0;
  localparam logic [2:0] OP_TBSC  = 3'h1;  // test_bit_skip_if_clear
  localparam logic [2:0] OP_TBSS  = 3'h2;  // test_bit_skip_if_set
  localparam logic [2:0] OP_CALL  = 3'h3;  // immediate call
  localparam logic [2:0] OP_CALLW = 3'h4;  // call_via_work_register

  // ----------------------------------------------------------------
  // Reset values and cycle counts
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RST    = 11'h000;
  localparam logic [SP_W-1:0] SP_RST    = 3'h0;
  localparam int              SKIP_CYC  = 2;
  localparam int              CALL_CYC  = 2;
  localparam int              PLAIN_CYC = 1;

endpackage

// ==== core/btsc_target.sv ====
// Call target former for the bit-test, skip and call unit.
// Assumes operands are stable in the cycle the call is decoded.
`timescale 1ns/1ps

module btsc_target
  import btsc_pkg::*;
(
  input  wire logic [2:0]        op,
  input  wire logic [DATA_W-1:0] imm,
  input  wire logic [HI_W-1:0]   pc_high_buffer,
  input  wire logic [HI_W-1:0]   table_high_pointer,
  input  wire logic [DATA_W-1:0] work_register,
  output logic      [PC_W-1:0]   target
);

  // ----------------------------------------------------------------
  // Target selection
  // ----------------------------------------------------------------
  // Only the low three bits of each high source reach the PC
  always_comb begin
    if (op == OP_CALLW) begin
      target = {table_high_pointer, work_register};
    end else begin
      target = {pc_high_buffer, imm};
    end
  end

endmodule

// ==== core/btsc_unit.sv ====
// Bit-test-and-skip and subroutine call execution unit.
// Assumes the core presents one decoded instruction per cycle on op
// while ready is high, with the addressed register value in reg_val.
// Stack storage lives outside; this unit drives a push strobe.
`timescale 1ns/1ps

// How it works
// - Clear bit tested: next instruction becomes no-op
// - Set bit tested: next instruction becomes no-op
// - Skip tests take one or two cycles
// - Calls push PC plus one, flags untouched
// - Immediate call: buffer high bits, operand low
// - Register call: pointer high bits, work low
module btsc_unit
  import btsc_pkg::*;
#(
  parameter int STACK_DEPTH = 8
)(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic [2:0]                  op,
  input  wire logic [btsc_pkg::DATA_W-1:0] reg_val,
  input  wire logic [btsc_pkg::BIT_W-1:0]  bit_sel,
  input  wire logic [btsc_pkg::DATA_W-1:0] imm,
  input  wire logic [btsc_pkg::HI_W-1:0]   pc_high_buffer,
  input  wire logic [btsc_pkg::HI_W-1:0]   table_high_pointer,
  input  wire logic [btsc_pkg::DATA_W-1:0] work_register,
  output logic      [btsc_pkg::PC_W-1:0]   pc_q,
  output logic                             ready_q,
  output logic                             nop_q,
  output logic                             push_q,
  output logic      [btsc_pkg::PC_W-1:0]   push_data_q,
  output logic      [btsc_pkg::SP_W-1:0]   push_slot_q,
  output logic      [btsc_pkg::SP_W-1:0]   sp_q,
  output logic                             flags_we_q
);
  import btsc_pkg::*;

  // Pointer width caps the depth; a single slot leaves nothing to walk
  if (STACK_DEPTH < 2 || STACK_DEPTH > (1 << SP_W)) begin : g_depth_chk
    $error("STACK_DEPTH out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_SKIP = 3'b010,
    ST_CALL = 3'b100
  } state_e;

  state_e            state_q;
  logic [PC_W-1:0]   target;
  logic [PC_W-1:0]   target_q;
  logic              bit_val;
  logic              take_skip;
  logic              is_call;
  logic              accept;

  btsc_target u_target (
    .op                 (op),
    .imm                (imm),
    .pc_high_buffer     (pc_high_buffer),
    .table_high_pointer (table_high_pointer),
    .work_register      (work_register),
    .target             (target)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // New instructions are only taken in the run state
  assign accept    = ce && (state_q == ST_RUN);
  assign bit_val   = reg_val[bit_sel];
  assign is_call   = (op == OP_CALL) || (op == OP_CALLW);
  assign take_skip = ((op == OP_TBSC) && !bit_val)
                  || ((op == OP_TBSS) && bit_val);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Second cycle of a skip or a call holds off the next instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_RUN;
      ready_q <= 1'b1;
      nop_q   <= 1'b0;
    end else if (ce) begin
      case (state_q)
        ST_RUN: begin
          nop_q <= 1'b0;
          if (take_skip) begin
            state_q <= ST_SKIP;
            ready_q <= 1'b0;
            nop_q   <= 1'b1;
          end else if (is_call) begin
            state_q <= ST_CALL;
            ready_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_RUN;
          ready_q <= 1'b1;
          nop_q   <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  // Fetched instruction sits at pc_q+1; a skip steps over it
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q     <= PC_RST;
      target_q <= PC_RST;
    end else if (ce) begin
      case (state_q)
        ST_RUN: begin
          if (is_call) begin
            target_q <= target;
            pc_q     <= pc_q;
          end else if (op != OP_NONE || take_skip) begin
            pc_q <= pc_q + 11'h001;
          end
        end
        ST_SKIP: pc_q <= pc_q + 11'h001;
        default: pc_q <= target_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Return stack push
  // ----------------------------------------------------------------
  // Pointer wraps at depth; overflow silently overwrites oldest slot
  always_ff @(posedge clk) begin
    if (rst) begin
      push_q      <= 1'b0;
      push_data_q <= PC_RST;
      push_slot_q <= SP_RST;
      sp_q        <= SP_RST;
    end else if (ce) begin
      push_q <= 1'b0;
      if (accept && is_call) begin
        push_q      <= 1'b1;
        push_data_q <= pc_q + 11'h001;
        push_slot_q <= sp_q;
        if (sp_q == SP_W'(STACK_DEPTH - 1)) begin
          sp_q <= SP_RST;
        end else begin
          sp_q <= sp_q + 3'h1;
        end
      end
    end
  end

  // Flag writes never come from these instructions
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_we_q <= 1'b0;
    end else if (ce) begin
      flags_we_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  skip_nop_a: assert property (@(posedge clk) disable iff (rst)
      ce && state_q == ST_RUN && take_skip |=> nop_q && !ready_q)
    else $error("skip did not issue a no-op");

  skip_clr_a: assert property (@(posedge clk) disable iff (rst)
      ce && state_q == ST_RUN && op == OP_TBSC && !bit_val |=> nop_q)
    else $error("clear-bit skip missed");

  skip_set_a: assert property (@(posedge clk) disable iff (rst)
      ce && state_q == ST_RUN && op == OP_TBSS && bit_val |=> nop_q)
    else $error("set-bit skip missed");

  no_skip_a: assert property (@(posedge clk) disable iff (rst)
      ce && state_q == ST_RUN && !take_skip && !is_call |=> ready_q)
    else $error("plain test took two cycles");

  skip_two_a: assert property (@(posedge clk) disable iff (rst)
      ce && state_q == ST_RUN && take_skip ##1 ce |=> ready_q)
    else $error("skip did not end after two cycles");

  // A busy cycle must ignore whatever op is still presented
  hold_off_a: assert property (@(posedge clk) disable iff (rst)
      ce && !ready_q |=> ready_q && !push_q && !nop_q)
    else $error("op taken while busy");

  push_addr_a: assert property (@(posedge clk) disable iff (rst)
      accept && is_call |=> push_q
        && push_data_q == $past(pc_q) + 11'h001)
    else $error("wrong return address pushed");

  call_imm_a: assert property (@(posedge clk) disable iff (rst)
      accept && op == OP_CALL ##1 ce |=>
        pc_q == {$past(pc_high_buffer, 2), $past(imm, 2)})
    else $error("immediate call target wrong");

  call_work_a: assert property (@(posedge clk) disable iff (rst)
      accept && op == OP_CALLW ##1 ce |=>
        pc_q == {$past(table_high_pointer, 2),
                 $past(work_register, 2)})
    else $error("register call target wrong");

  sp_step_a: assert property (@(posedge clk) disable iff (rst)
      accept && is_call && sp_q != SP_W'(STACK_DEPTH - 1) |=>
        sp_q == $past(sp_q) + 3'h1 && push_slot_q == $past(sp_q))
    else $error("stack pointer step wrong");

  sp_wrap_a: assert property (@(posedge clk) disable iff (rst)
      accept && is_call && sp_q == SP_W'(STACK_DEPTH - 1) |=>
        sp_q == SP_RST && push_slot_q == $past(sp_q))
    else $error("stack pointer wrap wrong");

  // Low enable must hold every register where it stands
  ce_hold_a: assert property (@(posedge clk) disable iff (rst)
      !ce |=> $stable(pc_q) && $stable(sp_q) && $stable(nop_q)
        && $stable(ready_q) && $stable(push_q))
    else $error("state moved with enable low");

  flags_a: assert property (@(posedge clk) disable iff (rst)
      !flags_we_q)
    else $error("flag write from skip or call");

endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the bit-test, skip and call unit.
// Assumes btsc_pkg and btsc_unit are compiled before this file.
`timescale 1ns/1ps

module tb_top;
  import btsc_pkg::*;
  // ------------------------------------------------------------
  // Stimulus, design and bookkeeping
  // ------------------------------------------------------------
  localparam logic [7:0] PAT = 8'h5A;
  logic              clk     = 1'b0;
  logic              rst     = 1'b1;
  logic              ce      = 1'b1;
  logic [2:0]        op      = OP_NONE;
  logic [DATA_W-1:0] reg_val = 8'h00;
  logic [BIT_W-1:0]  bit_sel = 3'h0;
  logic [DATA_W-1:0] imm     = 8'h00;
  logic [HI_W-1:0]   phb     = 3'h0;
  logic [HI_W-1:0]   thp     = 3'h0;
  logic [DATA_W-1:0] wreg    = 8'h00;
  logic [PC_W-1:0]   pc_q, push_data_q, exp_pc;
  logic [SP_W-1:0]   push_slot_q, sp_q, exp_sp;
  logic              ready_q, nop_q, push_q, flags_we_q;
  int                fail_count = 0;
  int                tests_run  = 0;

  // Half period of 12.5 ns gives 40 MHz
  always #12.5 clk = ~clk;

  btsc_unit #(.STACK_DEPTH(8)) btsc_unit_i (
    .clk(clk), .rst(rst), .ce(ce), .op(op), .reg_val(reg_val),
    .bit_sel(bit_sel), .imm(imm), .pc_high_buffer(phb),
    .table_high_pointer(thp), .work_register(wreg), .pc_q(pc_q),
    .ready_q(ready_q), .nop_q(nop_q), .push_q(push_q),
    .push_data_q(push_data_q), .push_slot_q(push_slot_q),
    .sp_q(sp_q), .flags_we_q(flags_we_q));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [PC_W-1:0] seen,
                       input logic [PC_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Op is taken at the edge after it is driven; sample once settled
  task automatic take();
    @(posedge clk);
    op <= OP_NONE;
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic skip_test(input logic [2:0] o, input logic [2:0] b,
                           input logic skip);
    @(posedge clk);
    op      <= o;
    reg_val <= PAT;
    bit_sel <= b;
    take();
    check("nop", nop_q, skip);
    check("ready", ready_q, !skip);
    check("pc", pc_q, 11'(exp_pc + 1));
    check("flags", flags_we_q, 1'b0);
    exp_pc = 11'(exp_pc + 1);
    if (skip) begin
      @(posedge clk);
      #1;
      check("nop end", nop_q, 1'b0);
      check("ready end", ready_q, 1'b1);
      check("pc skip", pc_q, 11'(exp_pc + 1));
      exp_pc = 11'(exp_pc + 1);
    end
    $display("test skip op %0d bit %0d done", o, b);
  endtask

  // Operand and work always differ, high sources unless v[5:3] equals v[7:5], so a swapped source shows in the target
  task automatic call_test(input logic [2:0] o, input logic [7:0] v);
    logic [PC_W-1:0] tgt;
    tgt = (o == OP_CALL) ? {v[5:3], v} : {v[7:5], ~v};
    @(posedge clk);
    op   <= o;
    imm  <= v;
    wreg <= ~v;
    phb  <= v[5:3];
    thp  <= v[7:5];
    take();
    check("push", push_q, 1'b1);
    check("ret addr", push_data_q, 11'(exp_pc + 1));
    check("slot", push_slot_q, exp_sp);
    check("sp", sp_q, 3'(exp_sp + 1));
    check("flags", flags_we_q, 1'b0);
    check("pc hold", pc_q, exp_pc);
    check("busy", ready_q, 1'b0);
    @(posedge clk);
    #1;
    check("target", pc_q, tgt);
    check("push end", push_q, 1'b0);
    check("ready", ready_q, 1'b1);
    exp_pc = tgt;
    exp_sp = 3'(exp_sp + 1);
    $display("test call op %0d value %h done", o, v);
  endtask

  // Other opcodes back to back only step the counter, one cycle each
  task automatic plain_test(input logic [2:0] o);
    @(posedge clk);
    op <= o;
    @(posedge clk);
    #1;
    check("plain pc 1", pc_q, 11'(exp_pc + 1));
    take();
    check("plain pc 2", pc_q, 11'(exp_pc + 2));
    check("plain ready", ready_q, 1'b1);
    check("plain nop", nop_q, 1'b0);
    check("plain push", push_q, 1'b0);
    exp_pc = 11'(exp_pc + 2);
    $display("test plain op %0d done", o);
  endtask

  // A call left on op through its busy cycle must push only once
  task automatic refuse_test();
    @(posedge clk);
    op  <= OP_CALL;
    imm <= 8'hC3;
    phb <= 3'h6;
    @(posedge clk);
    #1;
    check("held push", push_q, 1'b1);
    check("held ret", push_data_q, 11'(exp_pc + 1));
    check("held busy", ready_q, 1'b0);
    take();
    check("refused push", push_q, 1'b0);
    check("refused sp", sp_q, 3'(exp_sp + 1));
    check("held target", pc_q, 11'h6C3);
    check("held ready", ready_q, 1'b1);
    exp_pc = 11'h6C3;
    exp_sp = 3'(exp_sp + 1);
    $display("test refused op done");
  endtask

  // Low enable stalls both an idle cycle and the middle of a skip
  task automatic freeze_test();
    @(posedge clk);
    ce      <= 1'b0;
    op      <= OP_TBSS;
    reg_val <= PAT;
    bit_sel <= 3'h1;
    @(posedge clk);
    ce <= 1'b1;
    #1;
    check("frozen pc", pc_q, exp_pc);
    check("frozen nop", nop_q, 1'b0);
    @(posedge clk);
    op <= OP_NONE;
    ce <= 1'b0;
    #1;
    check("taken nop", nop_q, 1'b1);
    check("taken pc", pc_q, 11'(exp_pc + 1));
    @(posedge clk);
    ce <= 1'b1;
    #1;
    check("stall nop", nop_q, 1'b1);
    check("stall ready", ready_q, 1'b0);
    check("stall pc", pc_q, 11'(exp_pc + 1));
    @(posedge clk);
    #1;
    check("resume nop", nop_q, 1'b0);
    check("resume ready", ready_q, 1'b1);
    check("resume pc", pc_q, 11'(exp_pc + 2));
    exp_pc = 11'(exp_pc + 2);
    $display("test clock enable done");
  endtask

  // Reset in a call's busy cycle, enable low, clears every register
  task automatic reset_test();
    @(posedge clk);
    op   <= OP_CALLW;
    wreg <= 8'h77;
    thp  <= 3'h5;
    @(posedge clk);
    op  <= OP_NONE;
    rst <= 1'b1;
    ce  <= 1'b0;
    #1;
    check("pre push", push_q, 1'b1);
    @(posedge clk);
    #1;
    check("rst pc", pc_q, PC_RST);
    check("rst push", push_q, 1'b0);
    check("rst ret", push_data_q, PC_RST);
    check("rst sp", sp_q, SP_RST);
    check("rst slot", push_slot_q, SP_RST);
    check("rst ready", ready_q, 1'b1);
    check("rst nop", nop_q, 1'b0);
    // First op lands on the first edge after release
    @(posedge clk);
    rst     <= 1'b0;
    ce      <= 1'b1;
    op      <= OP_TBSC;
    reg_val <= PAT;
    bit_sel <= 3'h0;
    take();
    check("first nop", nop_q, 1'b1);
    check("first pc", pc_q, 11'(PC_RST + 1));
    @(posedge clk);
    #1;
    check("first end", pc_q, 11'(PC_RST + 2));
    exp_pc = 11'(PC_RST + 2);
    exp_sp = SP_RST;
    $display("test reset mid-call done");
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    exp_pc = PC_RST;
    exp_sp = SP_RST;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Every bit position, both outcomes for both skip kinds
    for (int b = 0; b < 8; b++) begin
      skip_test(OP_TBSC, 3'(b), ~PAT[b]);
      skip_test(OP_TBSS, 3'(b), PAT[b]);
    end
    // Opcodes outside the skip and call set
    for (int o = 5; o < 8; o++) begin
      plain_test(3'(o));
    end
    // Nine calls walk the stack pointer through its wrap
    for (int i = 0; i < 9; i++) begin
      call_test(i[0] ? OP_CALLW : OP_CALL, 8'(i * 37 + 11));
    end
    refuse_test();
    freeze_test();
    reset_test();
    // Stack restarts at slot zero after the mid-run reset
    call_test(OP_CALL, 8'h2B);
    wrap_up();
  end

  // Whole run needs about 100 cycles; the margin only catches a hang
  initial begin
    repeat (1000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule
